// File: pkg/twf_pkg.sv
// tape word formatter: shared constants, modes and states
// assumes a single 200 MHz clock domain for the whole formatter
package twf_pkg;

  localparam int CLK_MHZ = 200;

  localparam int WORD_W = 18;
  localparam int DATA_W = 16;
  localparam int CHAR_W = 8;
  localparam int NIB_W  = 4;
  localparam int FMT_W  = 4;
  localparam int NIBS   = 4;

  // format select codes
  localparam logic [3:0] FMT_NORMAL = 4'hc;
  localparam logic [3:0] FMT_SPLIT  = 4'hd;
  localparam logic [3:0] FMT_ALT    = 4'he;

  // bits 16 and 17 of every read word
  localparam int         FORCED_LSB = 16;
  localparam logic [1:0] FORCED_HI  = 2'h3;

  // characters per word, last character index
  localparam logic [1:0] LAST_PAIR  = 2'h1;
  localparam logic [1:0] LAST_SPLIT = 2'h3;

  // pulse widths in ns, then in cycles
  localparam int WORD_STROBE_NS  = 1000;
  localparam int DRIVE_PULSE_NS  = 50;
  localparam int MOTION_PULSE_NS = 100;
  localparam int WORD_STROBE_CYC = (WORD_STROBE_NS * CLK_MHZ) / 1000;
  localparam int DRIVE_PULSE_CYC = (DRIVE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int MOTION_PULSE_CYC = (MOTION_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  // asynchronous input vector layout
  localparam int SY_DATA  = 0;
  localparam int SY_CHAR  = 18;
  localparam int SY_PAR   = 26;
  localparam int SY_PRE   = 27;
  localparam int SY_CWS   = 28;
  localparam int SY_WT    = 29;
  localparam int SY_RCS   = 30;
  localparam int SY_START = 31;
  localparam int SYNC_W   = 32;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_SPLIT, MODE_ALT, MODE_BAD} twf_mode_t;

  typedef enum logic [2:0] {ST_IDLE, ST_DRIVE, ST_MOTION, ST_INIT, ST_RUN} twf_state_t;

endpackage

// File: pkg/twf_sel_if.sv
// tape word formatter: select toggle control bundle
// assumes both ends share clk; carries init, advance and toggle states
`timescale 1ns/1ps
`default_nettype none
interface twf_sel_if;
  import twf_pkg::*;
  logic      clear;
  logic      init;
  logic      reverseRead;
  logic      advance;
  twf_mode_t mode;
  logic      selLow;
  logic      selHigh;
  modport ctrl (output clear, output init, output reverseRead, output advance, output mode,
                input selLow, input selHigh);
  modport tog  (input clear, input init, input reverseRead, input advance, input mode,
                output selLow, output selHigh);
endinterface
`default_nettype wire

// File: src/twf_formatter.sv
// tape word formatter: packs tape characters into 18-bit words on reads,
// splits buffered words into characters on writes
// assumes pin inputs are asynchronous; control inputs come from logic on clk
//
// Function
// - decode format field into normal, split-nibble, alt-pack; others flag error
// - formatter enabled only while a transfer function is active
// - each read character strobe loads one or two latches, toggles then advance
// - reverse reads: low clear and split-only toggling; high set except alt-pack
// - forward alt-pack reads: low clear and held, high set and toggling
// - latch load order per mode and direction as selected by toggles
// - read words are 18 bits with bits 16 and 17 forced high
// - parity bit generated with every assembled read word
// - completed word sets request flag, giving one word-ready strobe, flag clears
// - start gives drive pulse, motion pulse, then init pulse loading toggles
// - on writes the init pulse also requests the first word
// - word strobe while enabled gives buffer load pulse capturing data lines
// - next write word requested only after buffer fully converted
// - toggles steer write mux; split-nibble drives output bits 4 to 7 low
// - write conversion advances only on write character strobes
// - write toggles for normal and split-nibble modes
// - forward read toggles for normal and split-nibble modes
// - alt-pack writes: low clear and held, high set and toggling
// - parity checked on each buffer load, mismatch sets parity error
// - write strobe before the host answered flags drive timing error
`timescale 1ns/1ps
`default_nettype none
module twf_formatter
  import twf_pkg::*;
#(
  parameter int unsigned STROBE_CYC = WORD_STROBE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               controllerReset,
  input  wire logic               transferFunctionActive,
  input  wire logic [FMT_W-1:0]   formatSelectField,
  input  wire logic               isWrite,
  input  wire logic               isReverse,
  input  wire logic               isPhaseEncoded,
  input  wire logic               startTransfer,
  input  wire logic               readCharStrobe,
  input  wire logic [CHAR_W-1:0]  readCharData,
  input  wire logic               transportWriteTiming,
  input  wire logic               preambleDone,
  input  wire logic               controllerWordStrobe,
  input  wire logic [WORD_W-1:0]  dataIn,
  input  wire logic               dataParityIn,
  output logic [WORD_W-1:0]       dataOut,
  output logic                    dataParityOut,
  output logic                    dataOe,
  output logic                    formatterEnable,
  output logic                    formatCodeError,
  output logic                    driveStartPulse,
  output logic                    motionStartPulse,
  output logic                    formatterInitPulse,
  output logic                    wordReadyStrobe,
  output logic                    bufferLoadPulse,
  output logic                    writeCharStrobe,
  output logic [CHAR_W-1:0]       formatterOutputBits,
  output logic                    parityError,
  output logic                    driveTimingError
);

  if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : g_bad_strobe
    $error("STROBE_CYC must lie between 1 and 255");
  end

  // pin synchroniser: the first stage feeds only the second
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] prev_r;
  logic [SYNC_W-1:0] asyncIn;
  logic [SYNC_W-1:0] rising;

  assign asyncIn = {startTransfer, readCharStrobe, transportWriteTiming, controllerWordStrobe,
                    preambleDone, dataParityIn, readCharData, dataIn};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= asyncIn;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // char and data lines go through the same two stages as their strobes
  logic              startEdge;
  logic              readEdge;
  logic              timingEdge;
  logic              wordEdge;
  logic              preambleLvl;
  logic              parityLvl;
  logic [CHAR_W-1:0] charLvl;
  logic [WORD_W-1:0] busLvl;

  assign rising      = sync2_r & ~prev_r;
  assign startEdge   = rising[SY_START];
  assign readEdge    = rising[SY_RCS];
  assign timingEdge  = rising[SY_WT];
  assign wordEdge    = rising[SY_CWS];
  assign preambleLvl = sync2_r[SY_PRE];
  assign parityLvl   = sync2_r[SY_PAR];
  assign charLvl     = sync2_r[SY_CHAR +: CHAR_W];
  assign busLvl      = sync2_r[SY_DATA +: WORD_W];

  // format decode
  twf_mode_t mode;
  logic      splitMode;
  logic      badMode;

  assign mode = (formatSelectField == FMT_NORMAL) ? MODE_NORMAL :
                (formatSelectField == FMT_SPLIT)  ? MODE_SPLIT  :
                (formatSelectField == FMT_ALT)    ? MODE_ALT    : MODE_BAD;
  assign splitMode = (mode == MODE_SPLIT);
  assign badMode   = (mode == MODE_BAD);

  // enable and error flags
  logic formatterEnable_r;
  logic formatCodeError_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      formatterEnable_r <= 1'b0;
      formatCodeError_r <= 1'b0;
    end else begin
      formatterEnable_r <= transferFunctionActive && !controllerReset;
      formatCodeError_r <= (formatterEnable_r && badMode) ||
                           (formatCodeError_r && !controllerReset);
    end
  end

  // start sequence: drive pulse, motion pulse, init on motion trailing edge
  twf_state_t       state_r;
  twf_state_t       state_nxt;
  logic [CNT_W-1:0] phaseCnt_r;
  logic [CNT_W-1:0] phaseCnt_nxt;

  always_comb begin
    state_nxt    = state_r;
    phaseCnt_nxt = phaseCnt_r;
    case (state_r)
      ST_IDLE: begin
        if (formatterEnable_r && startEdge && !badMode) begin
          state_nxt    = ST_DRIVE;
          phaseCnt_nxt = CNT_W'(DRIVE_PULSE_CYC - 1);
        end
      end
      ST_DRIVE: begin
        if (phaseCnt_r == '0) begin
          state_nxt    = ST_MOTION;
          phaseCnt_nxt = CNT_W'(MOTION_PULSE_CYC - 1);
        end else begin
          phaseCnt_nxt = phaseCnt_r - 1'b1;
        end
      end
      ST_MOTION: begin
        if (phaseCnt_r == '0) begin
          state_nxt = ST_INIT;
        end else begin
          phaseCnt_nxt = phaseCnt_r - 1'b1;
        end
      end
      ST_INIT, ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!formatterEnable_r || controllerReset) begin
      state_nxt = ST_IDLE;
    end
  end

  logic driveStartPulse_r;
  logic motionStartPulse_r;
  logic formatterInitPulse_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r              <= ST_IDLE;
      phaseCnt_r           <= '0;
      driveStartPulse_r    <= 1'b0;
      motionStartPulse_r   <= 1'b0;
      formatterInitPulse_r <= 1'b0;
    end else begin
      state_r              <= state_nxt;
      phaseCnt_r           <= phaseCnt_nxt;
      driveStartPulse_r    <= (state_nxt == ST_DRIVE);
      motionStartPulse_r   <= (state_nxt == ST_MOTION);
      formatterInitPulse_r <= (state_nxt == ST_INIT);
    end
  end

  // select toggles
  twf_sel_if sel ();

  logic run;
  logic readStep;
  logic writeCharStrobe_r;
  logic advance;

  assign run      = (state_r == ST_RUN);
  assign readStep = run && !isWrite && readEdge;
  assign advance  = readStep || writeCharStrobe_r;

  assign sel.clear       = controllerReset;
  assign sel.init        = (state_r == ST_INIT);
  // split-nibble reverse reads still run, but words come out scrambled
  assign sel.reverseRead = isReverse && !isWrite;
  assign sel.advance     = advance;
  assign sel.mode        = mode;

  twf_select_toggles u_toggles (
    .clk (clk),
    .rst (rst),
    .sel (sel)
  );

  logic [1:0] nibIdx;
  assign nibIdx = {sel.selHigh, sel.selLow};

  // characters per word
  logic [1:0] charCnt_r;
  logic       lastChar;
  logic       wordDone;

  assign lastChar = (charCnt_r == (splitMode ? LAST_SPLIT : LAST_PAIR));
  assign wordDone = advance && lastChar;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      charCnt_r <= '0;
    end else if (sel.init || controllerReset) begin
      charCnt_r <= '0;
    end else if (advance) begin
      charCnt_r <= lastChar ? 2'h0 : charCnt_r + 2'h1;
    end
  end

  // read latches: pairs A&B / C&D, or one nibble at a time in split mode
  logic [DATA_W-1:0] latch_r;
  logic [DATA_W-1:0] latch_nxt;

  always_comb begin
    latch_nxt = latch_r;
    for (int i = 0; i < NIBS; i++) begin
      if (readStep) begin
        if (splitMode && nibIdx == 2'(i)) begin
          latch_nxt[i*NIB_W +: NIB_W] = charLvl[NIB_W-1:0];
        end else if (!splitMode && sel.selHigh == (i >= 2)) begin
          latch_nxt[i*NIB_W +: NIB_W] = charLvl[(i%2)*NIB_W +: NIB_W];
        end
      end
    end
  end

  logic [WORD_W-1:0] dataOut_r;
  logic              dataParityOut_r;
  logic              dataOe_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r         <= '0;
      dataOut_r       <= '0;
      dataParityOut_r <= 1'b0;
      dataOe_r        <= 1'b0;
    end else begin
      latch_r  <= latch_nxt;
      dataOe_r <= formatterEnable_r && !isWrite && run;
      if (readStep && lastChar) begin
        dataOut_r       <= {FORCED_HI, latch_nxt};
        dataParityOut_r <= ~^{FORCED_HI, latch_nxt};
      end
    end
  end

  // word request and word-ready strobe
  logic             xferReq_r;
  logic [CNT_W-1:0] strobeCnt_r;
  logic             wordReadyStrobe_r;
  logic             strobeStart;
  logic             reqSet;

  assign strobeStart = xferReq_r && (strobeCnt_r == '0);
  assign reqSet      = wordDone ||
                       (isWrite && sel.init);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xferReq_r         <= 1'b0;
      strobeCnt_r       <= '0;
      wordReadyStrobe_r <= 1'b0;
    end else if (controllerReset) begin
      xferReq_r         <= 1'b0;
      strobeCnt_r       <= '0;
      wordReadyStrobe_r <= 1'b0;
    end else begin
      xferReq_r <= reqSet || (xferReq_r && !strobeStart);
      if (strobeStart) begin
        strobeCnt_r <= CNT_W'(STROBE_CYC);
      end else if (strobeCnt_r != '0) begin
        strobeCnt_r <= strobeCnt_r - 1'b1;
      end
      wordReadyStrobe_r <= strobeStart || (strobeCnt_r > CNT_W'(1));
    end
  end

  // write buffer, parity check and answer tracking
  logic [WORD_W-1:0] wbuf_r;
  logic              bufferLoad;
  logic              bufferLoadPulse_r;
  logic              awaiting_r;
  logic              parityError_r;
  logic              driveTimingError_r;

  assign bufferLoad = wordEdge && formatterEnable_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbuf_r             <= '0;
      bufferLoadPulse_r  <= 1'b0;
      awaiting_r         <= 1'b0;
      parityError_r      <= 1'b0;
      driveTimingError_r <= 1'b0;
    end else begin
      bufferLoadPulse_r <= bufferLoad;
      if (bufferLoad) begin
        wbuf_r <= busLvl;
      end
      // odd parity over word and parity bit
      parityError_r <= (bufferLoad && !(^{busLvl, parityLvl})) ||
                       (parityError_r && !controllerReset);
      awaiting_r <= (isWrite && strobeStart) ||
                    (awaiting_r && !bufferLoad && !controllerReset);
      driveTimingError_r <= (writeCharStrobe_r && awaiting_r) ||
                            (driveTimingError_r && !controllerReset);
    end
  end

  // write character strobes: every timing edge in NRZ, every other after preamble in PE
  logic peDiv_r;
  logic writeStrobe_nxt;
  logic peGate;

  assign peGate          = isPhaseEncoded && preambleLvl;
  assign writeStrobe_nxt = run && isWrite && timingEdge &&
                           (!isPhaseEncoded || (peGate && peDiv_r));

  // write mux: pair of nibbles by high toggle, or one nibble with top bits low
  logic [CHAR_W-1:0] writeChar;
  assign writeChar = splitMode ? {{NIB_W{1'b0}}, wbuf_r[nibIdx*NIB_W +: NIB_W]} :
                     (sel.selHigh ? wbuf_r[2*NIB_W +: CHAR_W] : wbuf_r[0 +: CHAR_W]);

  logic [CHAR_W-1:0] formatterOutputBits_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peDiv_r               <= 1'b0;
      writeCharStrobe_r     <= 1'b0;
      formatterOutputBits_r <= '0;
    end else begin
      if (!run) begin
        peDiv_r <= 1'b0;
      end else if (timingEdge && peGate) begin
        peDiv_r <= !peDiv_r;
      end
      writeCharStrobe_r     <= writeStrobe_nxt;
      formatterOutputBits_r <= isWrite ? writeChar : '0;
    end
  end

  assign dataOut             = dataOut_r;
  assign dataParityOut       = dataParityOut_r;
  assign dataOe              = dataOe_r;
  assign formatterEnable     = formatterEnable_r;
  assign formatCodeError     = formatCodeError_r;
  assign driveStartPulse     = driveStartPulse_r;
  assign motionStartPulse    = motionStartPulse_r;
  assign formatterInitPulse  = formatterInitPulse_r;
  assign wordReadyStrobe     = wordReadyStrobe_r;
  assign bufferLoadPulse     = bufferLoadPulse_r;
  assign writeCharStrobe     = writeCharStrobe_r;
  assign formatterOutputBits = formatterOutputBits_r;
  assign parityError         = parityError_r;
  assign driveTimingError    = driveTimingError_r;

endmodule
`default_nettype wire

// File: src/twf_select_toggles.sv
// tape word formatter: the two select toggles that order latches and characters
// assumes init and advance are single-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module twf_select_toggles
  import twf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  twf_sel_if.tog    sel
);

  logic selLow_r;
  logic selHigh_r;
  logic splitMode;
  logic highInit;
  logic highStep;

  assign splitMode = (sel.mode == MODE_SPLIT);
  // high starts set for alt-pack, inverted again for reverse reads
  assign highInit  = (sel.mode == MODE_ALT) ^ sel.reverseRead;
  // alternate strokes in split mode: high moves as low wraps
  assign highStep  = !splitMode || selLow_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selLow_r  <= 1'b0;
      selHigh_r <= 1'b0;
    end else if (sel.clear) begin
      selLow_r  <= 1'b0;
      selHigh_r <= 1'b0;
    end else if (sel.init) begin
      selLow_r  <= 1'b0;
      selHigh_r <= highInit;
    end else if (sel.advance) begin
      selLow_r  <= splitMode ? !selLow_r : selLow_r;
      selHigh_r <= highStep ? !selHigh_r : selHigh_r;
    end
  end

  assign sel.selLow  = selLow_r;
  assign sel.selHigh = selHigh_r;

endmodule
`default_nettype wire

// File: tb/twf_assertions.sv
// checker for the tape word formatter, bound to its top ports
// assumes one clk domain with async rst
`timescale 1ns/1ps
`default_nettype none
module twf_assertions
  import twf_pkg::*;
#(
  parameter int unsigned STROBE_CYC = WORD_STROBE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              transferFunctionActive,
  input  wire logic [FMT_W-1:0]  formatSelectField,
  input  wire logic              isWrite,
  input  wire logic [WORD_W-1:0] dataOut,
  input  wire logic              dataParityOut,
  input  wire logic              formatterEnable,
  input  wire logic              formatCodeError,
  input  wire logic              driveStartPulse,
  input  wire logic              motionStartPulse,
  input  wire logic              formatterInitPulse,
  input  wire logic              wordReadyStrobe,
  input  wire logic              bufferLoadPulse,
  input  wire logic              writeCharStrobe,
  input  wire logic [CHAR_W-1:0] formatterOutputBits
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic badCode;
  assign badCode = !(formatSelectField inside {FMT_NORMAL, FMT_SPLIT, FMT_ALT});

  property p_fmt; $rose(formatCodeError) |-> $past(badCode); endproperty
  a_fmt: assert property (p_fmt) else $error("format error on a valid code");
  property p_en; formatterEnable |-> $past(transferFunctionActive); endproperty
  a_en: assert property (p_en) else $error("enable without active transfer");
  property p_drv; $rose(driveStartPulse) |-> driveStartPulse[*8] ##1 driveStartPulse[*2]
    ##1 (!driveStartPulse && motionStartPulse); endproperty
  a_drv: assert property (p_drv) else $error("drive pulse width or handoff wrong");
  property p_mot; $rose(motionStartPulse) |-> motionStartPulse[*8] ##1 motionStartPulse[*8]
    ##1 motionStartPulse[*4] ##1 (formatterInitPulse && !motionStartPulse); endproperty
  a_mot: assert property (p_mot) else $error("motion pulse or init pulse wrong");
  property p_init; formatterInitPulse |=> !formatterInitPulse && !driveStartPulse; endproperty
  a_init: assert property (p_init) else $error("init pulse not single");
  property p_req; formatterInitPulse && isWrite |-> ##2 wordReadyStrobe; endproperty
  a_req: assert property (p_req) else $error("no first word request");
  property p_load; bufferLoadPulse |-> formatterEnable ##1 !bufferLoadPulse; endproperty
  a_load: assert property (p_load) else $error("bad buffer load pulse");
  property p_word; $rose(wordReadyStrobe) && !isWrite |->
    dataOut[17:16] == FORCED_HI && dataParityOut == ~^dataOut; endproperty
  a_word: assert property (p_word) else $error("read word top bits or parity wrong");
  property p_nib; writeCharStrobe && isWrite && formatSelectField == FMT_SPLIT |->
    ##2 formatterOutputBits[7:4] == 4'h0; endproperty
  a_nib: assert property (p_nib) else $error("split char upper bits not low");
endmodule
bind twf_formatter twf_assertions #(.STROBE_CYC(STROBE_CYC)) u_chk (.clk, .rst, .transferFunctionActive,
  .formatSelectField, .isWrite, .dataOut, .dataParityOut, .formatterEnable, .formatCodeError, .driveStartPulse,
  .motionStartPulse, .formatterInitPulse, .wordReadyStrobe, .bufferLoadPulse, .writeCharStrobe,
  .formatterOutputBits);
`default_nettype wire

// File: tb/twf_formatter_tb_top.sv
// testbench for the tape word formatter: decode, start, write, read, errors
// assumes host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module twf_formatter_tb_top;
  import twf_pkg::*;
  localparam int unsigned SC = 4;
  logic clk, rst, controllerReset, transferFunctionActive, isWrite, isReverse, isPhaseEncoded, startTransfer;
  logic readCharStrobe, transportWriteTiming, preambleDone, controllerWordStrobe, dataParityIn, dataParityOut;
  logic formatterEnable, formatCodeError, driveStartPulse, motionStartPulse, formatterInitPulse, wordReadyStrobe;
  logic bufferLoadPulse, writeCharStrobe, parityError, driveTimingError, noAnswer, badParity, capParity, dataOe, wrsQ;
  logic [FMT_W-1:0]  formatSelectField;
  logic [CHAR_W-1:0] readCharData, formatterOutputBits;
  logic [WORD_W-1:0] dataIn, dataOut, capWord;
  logic [7:0]        nWords;
  int                miscompares, n_compared, cyc, nReq;

  twf_formatter #(.STROBE_CYC(SC)) dut (.clk, .rst, .controllerReset, .transferFunctionActive, .formatSelectField,
    .isWrite, .isReverse, .isPhaseEncoded, .startTransfer, .readCharStrobe, .readCharData, .transportWriteTiming,
    .preambleDone, .controllerWordStrobe, .dataIn, .dataParityIn, .dataOut, .dataParityOut, .dataOe,
    .formatterEnable, .formatCodeError, .driveStartPulse, .motionStartPulse, .formatterInitPulse, .wordReadyStrobe,
    .bufferLoadPulse, .writeCharStrobe, .formatterOutputBits, .parityError, .driveTimingError);
  twf_host_model host (.clk, .rst, .isWrite, .wordReadyStrobe, .dataOut, .dataParityOut, .noAnswer, .badParity,
    .controllerWordStrobe, .dataIn, .dataParityIn, .capWord, .capParity, .nWords);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    wrsQ <= wordReadyStrobe;
    if (wordReadyStrobe && !wrsQ) nReq <= nReq + 1;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results;
    $display("compares %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk(18'(got), 18'(exp));
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // pins pass two synchronisers, so hold each level three cycles
  task automatic pin(ref logic p);
    p = 1'b1;
    cyc_n(3);
    p = 1'b0;
    cyc_n(3);
  endtask
  task automatic waitfor(ref logic s);
    int k;
    for (k = 0; k < 400 && s !== 1'b1; k++) cyc_n(1);
    chk1(s, 1'b1);
  endtask
  task automatic do_reset(input logic w, input logic r, input logic [3:0] f);
    rst = 1'b1;
    isWrite = w;
    isReverse = r;
    formatSelectField = f;
    transferFunctionActive = 1'b0;
    cyc_n(4);
    rst = 1'b0;
    nReq = 0;
    cyc_n(2);
    chk1(formatterEnable, 1'b0);
    transferFunctionActive = 1'b1;
    cyc_n(3);
    chk1(formatterEnable, 1'b1);
  endtask
  task automatic go;
    int k, dc, mc;
    dc = 0;
    mc = 0;
    startTransfer = 1'b1;
    for (k = 0; k < 80 && formatterInitPulse !== 1'b1; k++) begin
      cyc_n(1);
      if (k == 3) startTransfer = 1'b0;
      dc += int'(driveStartPulse);
      mc += int'(motionStartPulse);
    end
    chk1(formatterInitPulse, 1'b1);
    chk(18'(dc), 18'(DRIVE_PULSE_CYC));
    chk(18'(mc), 18'(MOTION_PULSE_CYC));
  endtask
  function automatic logic [7:0] expc(input logic [3:0] f, input logic [WORD_W-1:0] d, input int c);
    if (f == FMT_SPLIT) return {4'h0, d[4*c +: 4]};
    return d[8*(c ^ int'(f == FMT_ALT)) +: 8];
  endfunction
  task automatic wr_run(input logic [3:0] f);
    int w, c, n;
    logic [WORD_W-1:0] d;
    n = (f == FMT_SPLIT) ? 4 : 2;
    do_reset(1'b1, 1'b0, f);
    go();
    for (w = 0; w < 2; w++) begin
      waitfor(bufferLoadPulse);
      d = 18'h0a5c3 + 18'(w) * 18'h01111;
      for (c = 0; c < n; c++) begin
        cyc_n(3);
        chk(18'(formatterOutputBits), 18'(expc(f, d, c)));
        chk(18'(nReq), 18'(w + 1));
        pin(transportWriteTiming);
      end
    end
    chk1(driveTimingError, 1'b0);
    chk1(parityError, 1'b0);
    chk1(dataOe, 1'b0);
  endtask
  task automatic rd_run(input logic [3:0] f, input logic r);
    int w, c, n;
    logic [WORD_W-1:0] d;
    n = (f == FMT_SPLIT) ? 4 : 2;
    do_reset(1'b0, r, f);
    go();
    for (w = 0; w < 2; w++) begin
      d = {FORCED_HI, 16'h0000};
      for (c = 0; c < n; c++) begin
        readCharData = 8'h3c + 8'(w * 81) + 8'(c * 39);
        if (f == FMT_SPLIT) d[4*c +: 4] = readCharData[3:0];
        else d[8*(c ^ int'(f == FMT_ALT) ^ int'(r)) +: 8] = readCharData;
        pin(readCharStrobe);
      end
      cyc_n(4);
      chk(capWord, d);
      chk1(capParity, ~^d);
      chk(18'(nWords), 18'(w + 1));
      chk1(dataOe, 1'b1);
    end
  endtask

  initial begin
    int k;
    {controllerReset, startTransfer, readCharStrobe, transportWriteTiming, noAnswer, badParity, readCharData} = '0;
    {isPhaseEncoded, preambleDone, isWrite, isReverse, transferFunctionActive, wrsQ} = '0;
    formatSelectField = FMT_NORMAL;
    rst = 1'b1;
    {miscompares, n_compared, cyc, nReq} = '0;
    do_reset(1'b0, 1'b0, FMT_NORMAL);
    for (k = 0; k < 16; k++) begin
      formatSelectField = 4'(k);
      controllerReset = 1'b1;
      cyc_n(1);
      controllerReset = 1'b0;
      cyc_n(3);
      chk1(formatCodeError, !(k inside {12, 13, 14}));
    end
    do_reset(1'b1, 1'b0, 4'h0);
    pin(startTransfer);
    chk1(driveStartPulse, 1'b0);
    wr_run(FMT_NORMAL);
    wr_run(FMT_SPLIT);
    wr_run(FMT_ALT);
    // reverse split reads are never issued
    rd_run(FMT_NORMAL, 1'b0);
    rd_run(FMT_NORMAL, 1'b1);
    rd_run(FMT_ALT, 1'b0);
    rd_run(FMT_ALT, 1'b1);
    rd_run(FMT_SPLIT, 1'b0);
    badParity = 1'b1;
    do_reset(1'b1, 1'b0, FMT_NORMAL);
    go();
    waitfor(bufferLoadPulse);
    cyc_n(2);
    chk1(parityError, 1'b1);
    badParity = 1'b0;
    noAnswer = 1'b1;
    {isPhaseEncoded, preambleDone} = 2'b11;
    do_reset(1'b1, 1'b0, FMT_NORMAL);
    go();
    // phase-encoded: only every second timing edge strobes
    pin(transportWriteTiming);
    chk1(driveTimingError, 1'b0);
    pin(transportWriteTiming);
    cyc_n(2);
    chk1(driveTimingError, 1'b1);
    noAnswer = 1'b0;
    results();
  end
endmodule
`default_nettype wire

// File: tb/twf_host_model.sv
// host-side bus controller model: answers word requests, captures read words
// assumes the formatter shares clk; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module twf_host_model
  import twf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              isWrite,
  input  wire logic              wordReadyStrobe,
  input  wire logic [WORD_W-1:0] dataOut,
  input  wire logic              dataParityOut,
  input  wire logic              noAnswer,
  input  wire logic              badParity,
  output logic                   controllerWordStrobe,
  output logic [WORD_W-1:0]      dataIn,
  output logic                   dataParityIn,
  output logic [WORD_W-1:0]      capWord,
  output logic                   capParity,
  output logic [7:0]             nWords
);
  logic       seen_r;
  logic [3:0] hold_r;
  logic       rise;
  assign rise = wordReadyStrobe && !seen_r;
  assign dataIn = 18'h0a5c3 + 18'(nWords) * 18'h01111;
  assign dataParityIn = ~^dataIn ^ badParity;
  assign controllerWordStrobe = hold_r != 4'h0;
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      seen_r <= 1'b0;
      hold_r <= 4'h0;
      nWords <= 8'h00;
      capWord <= '0;
      capParity <= 1'b0;
    end else begin
      seen_r <= wordReadyStrobe;
      if (rise && !isWrite) begin
        capWord <= dataOut;
        capParity <= dataParityOut;
        nWords <= nWords + 8'h01;
      end
      // strobe held long enough to pass the pin synchronisers
      if (rise && isWrite && !noAnswer) hold_r <= 4'h6;
      else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
      if (hold_r == 4'h1) nWords <= nWords + 8'h01;
    end
  end
endmodule
`default_nettype wire
